/* hw/indexed_literal_offset_exec.sv */
// Executor for indexed add, bit set and set-all instructions with literal offset addressing
`timescale 1ns/1ns
`default_nettype none
module indexed_literal_offset_exec (
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic [ilo_pkg::BUS_AW-1:0] addr,
  input  wire logic [ilo_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output logic      [ilo_pkg::DATA_W-1:0] rd_data,
  output logic                            busy,
  output logic                            exec_done
);
  import ilo_pkg::*;

  core_state_t       state_r,     state_nxt;
  op_kind_t          op_r,        op_nxt;
  instr_t            instr_r,     instr_nxt;
  logic              ext_en_r,    ext_en_nxt;
  logic              bad_op_r,    bad_op_nxt;
  logic [MEM_AW-1:0] sfp_r,       sfp_nxt;
  logic [BANK_W-1:0] bank_sel_r,  bank_sel_nxt;
  logic [DATA_W-1:0] accum_r,     accum_nxt;
  flags_t            status_r,    status_nxt;
  flags_t            add_flags_r, add_flags_nxt;
  logic [MEM_AW-1:0] ea_r,        ea_nxt;
  logic [DATA_W-1:0] result_r,    result_nxt;
  logic [MEM_AW-1:0] mem_ptr_r,   mem_ptr_nxt;
  logic [DATA_W-1:0] rd_data_r,   rd_data_nxt;
  logic              rd_mem_r,    rd_mem_nxt;
  logic              done_r,      done_nxt;

  logic              a_we;
  logic              b_we;
  logic [DATA_W-1:0] a_q;
  logic [DATA_W-1:0] b_q;
  logic [DATA_W-1:0] add_sum;
  flags_t            add_flags;
  logic              idle;
  logic              is_add;
  logic              is_bset;
  logic              is_indexed_set_all_ones;
  logic              acc_bit;
  logic [DATA_W-1:0] file_addr;
  logic [BIT_SEL_W-1:0] bit_sel;

  data_ram u_ram (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .a_addr  (ea_r),
    .a_we    (a_we),
    .a_wdata (result_r),
    .a_q     (a_q),
    .b_addr  (mem_ptr_r),
    .b_we    (b_we),
    .b_wdata (wr_data),
    .b_q     (b_q)
  );

  add_flags_unit u_add (
    .op_a  (accum_r),
    .op_b  (a_q),
    .sum   (add_sum),
    .flags (add_flags)
  );

  assign idle      = (state_r == ST_IDLE);
  assign busy      = !idle;
  assign exec_done = done_r;
  // Memory window reads come straight from the RAM's output register
  assign rd_data   = rd_mem_r ? b_q : rd_data_r;

  // Field extraction of the latched instruction word
  assign file_addr = instr_r.file_addr;
  assign acc_bit   = instr_r.opcode_hi[OPC_A_BIT];
  assign bit_sel   = instr_r.opcode_hi[OPC_B_LSB +: BIT_SEL_W];
  assign is_add    = ((instr_r.opcode_hi & OPC_ADD_MASK) == OPC_ADD_VAL);
  assign is_bset   = ((instr_r.opcode_hi & OPC_BSET_MASK) == OPC_BSET_VAL);
  assign is_indexed_set_all_ones   = ((instr_r.opcode_hi & OPC_INDEXED_SET_ALL_ONES_MASK) == OPC_INDEXED_SET_ALL_ONES_VAL);

  always_comb begin
    state_nxt     = state_r;
    op_nxt        = op_r;
    instr_nxt     = instr_r;
    ext_en_nxt    = ext_en_r;
    bad_op_nxt    = bad_op_r;
    sfp_nxt       = sfp_r;
    bank_sel_nxt  = bank_sel_r;
    accum_nxt     = accum_r;
    status_nxt    = status_r;
    add_flags_nxt = add_flags_r;
    ea_nxt        = ea_r;
    result_nxt    = result_r;
    mem_ptr_nxt   = mem_ptr_r;
    rd_data_nxt   = RST_BYTE;
    rd_mem_nxt    = 1'b0;
    done_nxt      = 1'b0;
    a_we          = 1'b0;
    b_we          = 1'b0;

    // Register writes; state the core reads is frozen while an instruction runs, except the extended-set enable in the control register
    if (wr_stb) begin
      if (addr == REG_CTRL) begin
        ext_en_nxt = wr_data[CTRL_EXT_BIT];
        if (wr_data[CTRL_BAD_BIT]) begin
          bad_op_nxt = 1'b0;
        end
      end else if (addr == REG_SFP_LO) begin
        if (idle) begin
          sfp_nxt[DATA_W-1:0] = wr_data;
        end
      end else if (addr == REG_SFP_HI) begin
        if (idle) begin
          sfp_nxt[MEM_AW-1:DATA_W] = wr_data[BANK_W-1:0];
        end
      end else if (addr == REG_ACCUM) begin
        if (idle) begin
          accum_nxt = wr_data;
        end
      end else if (addr == REG_STATUS) begin
        if (idle) begin
          status_nxt = wr_data[FLAGS_W-1:0];
        end
      end else if (addr == REG_BANK_SEL) begin
        if (idle) begin
          bank_sel_nxt = wr_data[BANK_W-1:0];
        end
      end else if (addr == REG_INSTR_LO) begin
        if (idle) begin
          instr_nxt.file_addr = wr_data;
        end
      end else if (addr == REG_INSTR_HI) begin
        // Writing the high byte launches the one-word instruction
        if (idle) begin
          instr_nxt.opcode_hi = wr_data;
          state_nxt           = ST_DECODE;
        end
      end else if (addr == REG_MEM_PTR_LO) begin
        mem_ptr_nxt[DATA_W-1:0] = wr_data;
      end else if (addr == REG_MEM_PTR_HI) begin
        mem_ptr_nxt[MEM_AW-1:DATA_W] = wr_data[BANK_W-1:0];
      end else if (addr == REG_MEM_DATA) begin
        if (idle) begin
          b_we = 1'b1;
        end
      end
    end

    if (rd_stb) begin
      if (addr == REG_CTRL) begin
        rd_data_nxt[CTRL_EXT_BIT]  = ext_en_r;
        rd_data_nxt[CTRL_BUSY_BIT] = !idle;
        rd_data_nxt[CTRL_BAD_BIT]  = bad_op_r;
      end else if (addr == REG_SFP_LO) begin
        rd_data_nxt = sfp_r[DATA_W-1:0];
      end else if (addr == REG_SFP_HI) begin
        rd_data_nxt[BANK_W-1:0] = sfp_r[MEM_AW-1:DATA_W];
      end else if (addr == REG_ACCUM) begin
        rd_data_nxt = accum_r;
      end else if (addr == REG_STATUS) begin
        rd_data_nxt[FLAGS_W-1:0] = status_r;
      end else if (addr == REG_BANK_SEL) begin
        rd_data_nxt[BANK_W-1:0] = bank_sel_r;
      end else if (addr == REG_INSTR_LO) begin
        rd_data_nxt = instr_r.file_addr;
      end else if (addr == REG_INSTR_HI) begin
        rd_data_nxt = instr_r.opcode_hi;
      end else if (addr == REG_MEM_PTR_LO) begin
        rd_data_nxt = mem_ptr_r[DATA_W-1:0];
      end else if (addr == REG_MEM_PTR_HI) begin
        rd_data_nxt[BANK_W-1:0] = mem_ptr_r[MEM_AW-1:DATA_W];
      end else if (addr == REG_MEM_DATA) begin
        rd_mem_nxt = 1'b1;
      end
    end

    case (state_r)
      ST_IDLE: begin
      end
      ST_DECODE: begin
        if (is_add) begin
          op_nxt = OP_ADD;
        end else if (is_bset) begin
          op_nxt = OP_BSET;
        end else begin
          op_nxt = OP_SETALL;
        end
        // Effective address: indexed only with the extended set on and access bit clear
        if (ext_en_r && !acc_bit && (file_addr <= INDEX_LIMIT)) begin
          ea_nxt = sfp_r + {{BANK_W{1'b0}}, file_addr};
        end else if (!acc_bit) begin
          if (file_addr <= INDEX_LIMIT) begin
            ea_nxt = {ACCESS_LO_BANK, file_addr};
          end else begin
            ea_nxt = {ACCESS_HI_BANK, file_addr};
          end
        end else begin
          ea_nxt = {bank_sel_r, file_addr};
        end
        if (is_add || is_bset || is_indexed_set_all_ones) begin
          state_nxt = ST_READ;
        end else begin
          // Unknown opcode ends at once; the sticky flag set wins over a clear this cycle
          bad_op_nxt = 1'b1;
          done_nxt   = 1'b1;
          state_nxt  = ST_IDLE;
        end
      end
      ST_READ: begin
        // RAM port A addresses ea_r; its output register is valid in the next phase
        state_nxt = ST_PROCESS;
      end
      ST_PROCESS: begin
        case (op_r)
          OP_ADD: begin
            result_nxt    = add_sum;
            add_flags_nxt = add_flags;
          end
          OP_BSET: begin
            result_nxt = a_q | (BIT_ONE << bit_sel);
          end
          default: begin
            result_nxt = ALL_ONES;
          end
        endcase
        state_nxt = ST_WRITE;
      end
      ST_WRITE: begin
        if ((op_r == OP_ADD) && !instr_r.opcode_hi[OPC_D_BIT]) begin
          accum_nxt = result_r;
        end else begin
          a_we = 1'b1;
        end
        // Bit set and set-all leave the status register untouched
        if (op_r == OP_ADD) begin
          status_nxt = add_flags_r;
        end
        done_nxt  = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r     <= ST_IDLE;
      op_r        <= OP_ADD;
      instr_r     <= '0;
      ext_en_r    <= 1'b0;
      bad_op_r    <= 1'b0;
      sfp_r       <= RST_ADDR;
      bank_sel_r  <= RST_BANK;
      accum_r     <= RST_BYTE;
      status_r    <= '0;
      add_flags_r <= '0;
      ea_r        <= RST_ADDR;
      result_r    <= RST_BYTE;
      mem_ptr_r   <= RST_ADDR;
      rd_data_r   <= RST_BYTE;
      rd_mem_r    <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      op_r        <= op_nxt;
      instr_r     <= instr_nxt;
      ext_en_r    <= ext_en_nxt;
      bad_op_r    <= bad_op_nxt;
      sfp_r       <= sfp_nxt;
      bank_sel_r  <= bank_sel_nxt;
      accum_r     <= accum_nxt;
      status_r    <= status_nxt;
      add_flags_r <= add_flags_nxt;
      ea_r        <= ea_nxt;
      result_r    <= result_nxt;
      mem_ptr_r   <= mem_ptr_nxt;
      rd_data_r   <= rd_data_nxt;
      rd_mem_r    <= rd_mem_nxt;
      done_r      <= done_nxt;
    end
  end
endmodule
`default_nettype wire

/* hw/ilo_pkg.sv */
// Shared constants, types and register map for the indexed literal offset executor
package ilo_pkg;

  localparam int unsigned BUS_AW   = 4;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned MEM_AW   = 12;
  localparam int unsigned BANK_W   = MEM_AW - DATA_W;

  // Register offsets on the plain register port
  localparam logic [BUS_AW-1:0] REG_CTRL       = 4'h0;
  localparam logic [BUS_AW-1:0] REG_SFP_LO     = 4'h1;
  localparam logic [BUS_AW-1:0] REG_SFP_HI     = 4'h2;
  localparam logic [BUS_AW-1:0] REG_ACCUM      = 4'h3;
  localparam logic [BUS_AW-1:0] REG_STATUS     = 4'h4;
  localparam logic [BUS_AW-1:0] REG_BANK_SEL   = 4'h5;
  localparam logic [BUS_AW-1:0] REG_INSTR_LO   = 4'h6;
  localparam logic [BUS_AW-1:0] REG_INSTR_HI   = 4'h7;
  localparam logic [BUS_AW-1:0] REG_MEM_PTR_LO = 4'h8;
  localparam logic [BUS_AW-1:0] REG_MEM_PTR_HI = 4'h9;
  localparam logic [BUS_AW-1:0] REG_MEM_DATA   = 4'hA;

  // Control register fields
  localparam int unsigned CTRL_EXT_BIT  = 0;
  localparam int unsigned CTRL_BUSY_BIT = 1;
  localparam int unsigned CTRL_BAD_BIT  = 2;

  // Reset values
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [MEM_AW-1:0] RST_ADDR = 12'h000;
  localparam logic [BANK_W-1:0] RST_BANK = 4'h0;

  // Opcode high byte patterns, compared under a mask
  localparam logic [DATA_W-1:0] OPC_ADD_MASK  = 8'hFC;
  localparam logic [DATA_W-1:0] OPC_ADD_VAL   = 8'h24;
  localparam logic [DATA_W-1:0] OPC_BSET_MASK = 8'hF0;
  localparam logic [DATA_W-1:0] OPC_BSET_VAL  = 8'h80;
  localparam logic [DATA_W-1:0] OPC_INDEXED_SET_ALL_ONES_MASK = 8'hFE;
  localparam logic [DATA_W-1:0] OPC_INDEXED_SET_ALL_ONES_VAL  = 8'h68;
  localparam int unsigned       OPC_A_BIT     = 0;
  localparam int unsigned       OPC_D_BIT     = 1;
  localparam int unsigned       OPC_B_LSB     = 1;
  localparam int unsigned       BIT_SEL_W     = 3;

  // Addressing
  localparam logic [DATA_W-1:0] INDEX_LIMIT     = 8'h5F;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK  = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK  = 4'hF;
  localparam logic [DATA_W-1:0] ALL_ONES        = 8'hFF;
  localparam logic [DATA_W-1:0] BIT_ONE         = 8'h01;
  localparam logic [DATA_W-1:0] NIBBLE_MASK     = 8'h0F;
  localparam int unsigned       NIBBLE_W        = 4;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } flags_t;

  localparam int unsigned FLAGS_W = $bits(flags_t);

  typedef struct packed {
    logic [DATA_W-1:0] opcode_hi;
    logic [DATA_W-1:0] file_addr;
  } instr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_READ,
    ST_PROCESS,
    ST_WRITE
  } core_state_t;

  typedef enum logic [1:0] {
    OP_ADD,
    OP_BSET,
    OP_SETALL
  } op_kind_t;

endpackage

/* hw/data_ram.sv */
// Two-port byte data memory with registered read data on each port
`timescale 1ns/1ns
`default_nettype none
module data_ram (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire logic [ilo_pkg::MEM_AW-1:0] a_addr,
  input  wire logic                      a_we,
  input  wire logic [ilo_pkg::DATA_W-1:0] a_wdata,
  output logic      [ilo_pkg::DATA_W-1:0] a_q,
  input  wire logic [ilo_pkg::MEM_AW-1:0] b_addr,
  input  wire logic                      b_we,
  input  wire logic [ilo_pkg::DATA_W-1:0] b_wdata,
  output logic      [ilo_pkg::DATA_W-1:0] b_q
);
  import ilo_pkg::*;

  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

  // One process owns the array; port A is written last so it wins a same-address clash
  always_ff @(posedge clk_sys) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end

  // Read data show the contents before any write of the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      a_q <= RST_BYTE;
      b_q <= RST_BYTE;
    end else begin
      a_q <= mem[a_addr];
      b_q <= mem[b_addr];
    end
  end
endmodule
`default_nettype wire

/* hw/add_flags_unit.sv */
// Eight-bit adder producing the arithmetic status flags
`timescale 1ns/1ns
`default_nettype none
module add_flags_unit (
  input  wire logic [ilo_pkg::DATA_W-1:0] op_a,
  input  wire logic [ilo_pkg::DATA_W-1:0] op_b,
  output logic      [ilo_pkg::DATA_W-1:0] sum,
  output ilo_pkg::flags_t                 flags
);
  import ilo_pkg::*;

  logic [DATA_W:0]     full;
  logic [NIBBLE_W:0]   low;

  always_comb begin
    full     = {1'b0, op_a} + {1'b0, op_b};
    low      = {1'b0, op_a[NIBBLE_W-1:0]} + {1'b0, op_b[NIBBLE_W-1:0]};
    sum      = full[DATA_W-1:0];
    flags.c  = full[DATA_W];
    flags.dc = low[NIBBLE_W];
    flags.z  = (full[DATA_W-1:0] == RST_BYTE);
    flags.n  = full[DATA_W-1];
    // Signed overflow: equal operand signs, different result sign
    flags.ov = (op_a[DATA_W-1] == op_b[DATA_W-1]) && (full[DATA_W-1] != op_a[DATA_W-1]);
  end
endmodule
`default_nettype wire

/* test/ilo_chk.sv */
// Port-level assertions for the indexed literal offset executor
`timescale 1ns/1ns
`default_nettype none
module ilo_chk (
  input wire logic                       clk_sys,
  input wire logic                       resetn,
  input wire logic [ilo_pkg::BUS_AW-1:0] addr,
  input wire logic [ilo_pkg::DATA_W-1:0] wr_data,
  input wire logic                       wr_stb,
  input wire logic                       rd_stb,
  input wire logic [ilo_pkg::DATA_W-1:0] rd_data,
  input wire logic                       busy,
  input wire logic                       exec_done
);
  import ilo_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  logic launch;
  logic hi_add;
  logic hi_bset;
  logic hi_set;

  // A launch while busy is refused, so it never starts a run
  assign launch  = wr_stb && addr == REG_INSTR_HI && !busy;
  assign hi_add  = (wr_data & OPC_ADD_MASK) == OPC_ADD_VAL;
  assign hi_bset = (wr_data & OPC_BSET_MASK) == OPC_BSET_VAL;
  assign hi_set  = (wr_data & OPC_INDEXED_SET_ALL_ONES_MASK) == OPC_INDEXED_SET_ALL_ONES_VAL;

  sequence s_four_phase;
    busy [*4] ##1 (exec_done && !busy);
  endsequence

  sequence s_bad_end;
    !exec_done ##1 exec_done;
  endsequence

  property p_add;
    launch && hi_add |=> s_four_phase;
  endproperty
  property p_bset;
    launch && hi_bset |=> s_four_phase;
  endproperty
  property p_set;
    launch && hi_set |=> s_four_phase;
  endproperty
  property p_bad;
    launch && !(hi_add || hi_bset || hi_set) |=> s_bad_end;
  endproperty
  property p_pulse;
    exec_done |-> !busy ##1 !exec_done;
  endproperty
  property p_cause;
    exec_done |-> $past(launch, 5) || $past(launch, 2);
  endproperty
  property p_busy_rise;
    $rose(busy) |-> $past(launch);
  endproperty
  property p_ctrl_read;
    rd_stb && addr == REG_CTRL |=> rd_data[7:3] == 5'h00 && rd_data[CTRL_BUSY_BIT] == $past(busy);
  endproperty
  property p_status_read;
    rd_stb && addr == REG_STATUS |=> rd_data[7:5] == 3'h0;
  endproperty

  a_add: assert property (p_add) else $error("add run not four busy cycles then done");
  a_bset: assert property (p_bset) else $error("bit set run not four busy cycles then done");
  a_set: assert property (p_set) else $error("set-all run not four busy cycles then done");
  a_bad: assert property (p_bad) else $error("unknown opcode did not end after decode");
  a_pulse: assert property (p_pulse) else $error("done not a single cycle pulse with busy low");
  a_cause: assert property (p_cause) else $error("done without a matching launch");
  a_busy_rise: assert property (p_busy_rise) else $error("busy rose without a launch");
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read busy bit wrong");
  a_status_read: assert property (p_status_read) else $error("status holds more than five flags");
endmodule
bind indexed_literal_offset_exec ilo_chk chk_u (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
  .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .busy(busy), .exec_done(exec_done));
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the indexed literal offset executor
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ilo_pkg::*;
  logic              clk_sys;
  logic              resetn;
  logic [BUS_AW-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_stb;
  logic              rd_stb;
  logic [DATA_W-1:0] rd_data;
  logic              busy;
  logic              exec_done;
  int                mismatches;
  int                n_tests;
  logic [MEM_AW-1:0] sfp;
  logic [BANK_W-1:0] bank;
  logic              ext;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] st;
  logic [DATA_W-1:0] q;

  indexed_literal_offset_exec dut_u (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .busy(busy), .exec_done(exec_done));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge clk_sys);
    wr_stb  <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rd(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    chk(rd_data, exp);
  endtask

  task automatic set_sfp(input logic [MEM_AW-1:0] v);
    sfp = v;
    wr(REG_SFP_LO, sfp[7:0]);
    wr(REG_SFP_HI, {4'h0, sfp[11:8]});
  endtask

  function automatic logic [MEM_AW-1:0] ea(input logic [DATA_W-1:0] hi, input logic [DATA_W-1:0] f);
    if (hi[OPC_A_BIT])
      return {bank, f};
    if (ext && f <= INDEX_LIMIT)
      return sfp + MEM_AW'(f);
    return {(f <= INDEX_LIMIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, f};
  endfunction

  function automatic logic [DATA_W-1:0] add_st(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    logic [DATA_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return {3'h0, s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
            ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F, s[8]};
  endfunction

  task automatic run(input logic [DATA_W-1:0] hi, input logic [DATA_W-1:0] f);
    logic [MEM_AW-1:0] m;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] r;
    int                n;
    m   = ea(hi, f);
    v   = DATA_W'($urandom);
    acc = DATA_W'($urandom);
    st  = {3'h0, 5'($urandom)};
    wr(REG_MEM_PTR_LO, m[7:0]);
    wr(REG_MEM_PTR_HI, {4'h0, m[11:8]});
    wr(REG_MEM_DATA, v);
    wr(REG_ACCUM, acc);
    wr(REG_STATUS, st);
    wr(REG_INSTR_LO, f);
    wr(REG_INSTR_HI, hi);
    // Lands mid-run and must be dropped
    wr(REG_ACCUM, ~acc);
    // Sampled in the write phase, so the busy bit must read one
    rd(REG_CTRL, {6'h00, 1'b1, ext});
    n = 0;
    while (exec_done !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h00, exec_done}, 8'h01);
    r = v;
    if ((hi & OPC_ADD_MASK) == OPC_ADD_VAL) begin
      st = add_st(acc, v);
      if (hi[OPC_D_BIT])
        r = acc + v;
      else
        acc = acc + v;
    end else if ((hi & OPC_BSET_MASK) == OPC_BSET_VAL)
      r = v | (BIT_ONE << hi[3:1]);
    else
      r = ALL_ONES;
    rd(REG_ACCUM, acc);
    rd(REG_STATUS, st);
    rd(REG_MEM_DATA, r);
    $display("test op %h offset %h ext %0d done", hi, f, ext);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // About four times the expected run length
  initial begin
    #(50 * 6000);
    mismatches++;
    print_verdict();
  end

  initial begin
    resetn     = 1'b0;
    addr       = '0;
    wr_data    = '0;
    wr_stb     = 1'b0;
    rd_stb     = 1'b0;
    mismatches = 0;
    n_tests    = 0;
    ext        = 1'b0;
    void'($urandom(96995));
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++)
      if (i != REG_MEM_DATA)
        rd(BUS_AW'(i), RST_BYTE);
    wr(4'hB, 8'hFF);
    rd(4'hB, 8'h00);
    $display("test reset and unmapped done");
    bank = BANK_W'($urandom);
    wr(REG_BANK_SEL, {4'h0, bank});
    rd(REG_BANK_SEL, {4'h0, bank});
    set_sfp(MEM_AW'($urandom));
    rd(REG_SFP_HI, {4'h0, sfp[11:8]});
    rd(REG_SFP_LO, sfp[7:0]);
    for (int e = 0; e < 2; e++) begin
      ext = e[0];
      wr(REG_CTRL, {7'h00, ext});
      rd(REG_CTRL, {7'h00, ext});
      run(8'h24, 8'h5F);
      run(8'h26, 8'h60);
      run(8'h25, 8'h10);
      run(8'h8E, 8'h00);
      run(8'h69, 8'h30);
      run(8'h83, 8'h70);
    end
    for (int b = 0; b < 8; b++)
      run({4'h8, 3'(b), 1'b0}, 8'(b * 12));
    set_sfp(12'hFFF);
    run(8'h68, 8'h5F);
    run(8'h26, 8'h01);
    for (int i = 0; i < 30; i++) begin
      set_sfp(MEM_AW'($urandom));
      case ($urandom_range(0, 2))
        0: q = {6'h09, 1'($urandom), 1'b0};
        1: q = {4'h8, 3'($urandom), 1'b0};
        default: q = 8'h68;
      endcase
      run(q, DATA_W'($urandom_range(0, 95)));
    end
    wr(REG_INSTR_HI, 8'h00);
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk({7'h00, exec_done}, 8'h01);
    rd(REG_CTRL, 8'h05);
    wr(REG_CTRL, 8'h05);
    rd(REG_CTRL, 8'h01);
    // An unknown opcode must leave accumulator and flags as the last run left them
    rd(REG_ACCUM, acc);
    rd(REG_STATUS, st);
    $display("test unknown opcode done");
    // Reset lands in the decode phase of a set-all; control, accumulator and memory pointer must come back idle and cleared
    wr(REG_INSTR_HI, 8'h68);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(REG_CTRL, RST_BYTE);
    rd(REG_ACCUM, RST_BYTE);
    rd(REG_MEM_PTR_LO, RST_BYTE);
    $display("test reset mid-run done");
    print_verdict();
  end
endmodule
`default_nettype wire
